// file: src/dma_xfer_defines.svh
`ifndef DMA_XFER_DEFINES_SVH
`define DMA_XFER_DEFINES_SVH

// Register byte offsets
`define OFF_CTRL 4'h0
`define OFF_SRC 4'h4
`define OFF_DST 4'h8
`define OFF_COUNT 4'hc

`define OFF_STATUS 5'h10
`define OFF_HOLD 5'h14

// Control register fields
`define CTRL_START 0
`define CTRL_EXT 1
`define CTRL_UNIT_LO 2
`define CTRL_PORT_LO 4
`define CTRL_SRC_IO 6
`define CTRL_DST_IO 7
`define CTRL_CONT 8
`define CTRL_PIN_SEL 9
`define CTRL_LEVEL 12
`define CTRL_POL 13
`define CTRL_BUS_LO 16
`define CTRL_MASK 32'h0003_33fe
`define CTRL_RESET 32'h0000_0000

// Status register fields
`define STAT_ACTIVE 0
`define STAT_DONE 1
`define STAT_ABN 2
`define STAT_CONF 3

// Size codes
`define SIZE_16 2'h2
`define SIZE_8 2'h3
`define BYTES_32 3'h4
`define BYTES_16 3'h2
`define BYTES_8 3'h1

`endif

// file: src/dma_xfer_pkg.sv
package dma_xfer_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_STANDBY = 5'h02,
    ST_READ = 5'h04,
    ST_WRITE = 5'h08,
    ST_ACK = 5'h10
  } chan_state_t;
endpackage

// file: src/dma_ext_request_dual_xfer.sv
// Our own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "dma_xfer_defines.svh"

module dma_ext_request_dual_xfer
  import dma_xfer_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transfer requests and acknowledge
  input wire logic interrupt_controller_transfer_request_n,
  input wire logic pin_transfer_request_n,
  output logic transfer_acknowledge_n,
  // Data bus master
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack
);

  function automatic logic [2:0] size_bytes(input logic [1:0] code);
    if (!code[1]) return `BYTES_32;
    else if (code == `SIZE_16) return `BYTES_16;
    else return `BYTES_8;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [2:0] nbytes);
    if (nbytes == `BYTES_32) return 32'hffff_ffff;
    else if (nbytes == `BYTES_16) return 32'h0000_ffff;
    else return 32'h0000_00ff;
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) old[8*i +: 8] = nw[8*i +: 8];
    end
    return old;
  endfunction

  chan_state_t state;
  logic [31:0] ctrl;
  logic [ADDR_W-1:0] src_addr;
  logic [ADDR_W-1:0] dst_addr;
  logic [CNT_W-1:0] byte_count;
  logic [31:0] holding_register;
  logic flag_done;
  logic flag_abn;
  logic flag_conf;
  logic start_pending;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic edge_pending;

  wire logic wb_hit = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire logic wb_wr = wb_hit & wb_we_i;
  wire logic idle = (state == ST_IDLE);

  wire logic [2:0] unit_bytes = size_bytes(ctrl[`CTRL_UNIT_LO +: 2]);
  wire logic [2:0] port_bytes = size_bytes(ctrl[`CTRL_PORT_LO +: 2]);
  wire logic [2:0] bus_bytes = size_bytes(ctrl[`CTRL_BUS_LO +: 2]);
  wire logic use_pin = ctrl[`CTRL_PIN_SEL];
  wire logic level_mode = ctrl[`CTRL_LEVEL];
  wire logic continuous = ctrl[`CTRL_CONT];

  // Access width of the current phase
  wire logic [2:0] src_dev = ctrl[`CTRL_SRC_IO] ? port_bytes : bus_bytes;
  wire logic [2:0] dst_dev = ctrl[`CTRL_DST_IO] ? port_bytes : bus_bytes;
  wire logic [2:0] rd_step = (src_dev < unit_bytes) ? src_dev : unit_bytes;
  wire logic [2:0] wr_step = (dst_dev < unit_bytes) ? dst_dev : unit_bytes;
  wire logic [2:0] step = (state == ST_WRITE) ? wr_step : rd_step;
  logic [2:0] piece_off;
  wire logic last_piece = (3'(piece_off + step) == unit_bytes);

  wire logic [CNT_W-1:0] unit_cnt = CNT_W'(unit_bytes);
  wire logic [CNT_W-1:0] count_after = byte_count - unit_cnt;
  wire logic [1:0] misalign_mask = 2'(unit_bytes - 3'h1);

  // Setup checks made when the channel is started
  wire logic cfg_error =
      (port_bytes > unit_bytes) |
      (ctrl[`CTRL_SRC_IO] & ctrl[`CTRL_DST_IO]) |
      !ctrl[`CTRL_EXT] |
      ctrl[`CTRL_POL] |
      (use_pin & (continuous != level_mode)) |
      (byte_count == '0) |
      flag_done | flag_abn |
      ((byte_count[1:0] & misalign_mask) != 2'h0) |
      ((src_addr[1:0] & misalign_mask) != 2'h0) |
      ((dst_addr[1:0] & misalign_mask) != 2'h0);

  // Pin synchroniser, idle high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      pin_meta <= pin_transfer_request_n;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire logic pin_fell = pin_prev & !pin_sync;
  wire logic consume = (state == ST_STANDBY || state == ST_ACK) && edge_pending;

  // Falling edge held until a unit is started
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) edge_pending <= 1'b0;
    else if (idle) edge_pending <= 1'b0;
    else edge_pending <= (pin_fell & use_pin & !level_mode) | (edge_pending & !consume);
  end

  wire logic req_now = !use_pin ? !interrupt_controller_transfer_request_n :
                       level_mode ? !pin_sync : edge_pending;

  // Wishbone slave: ack one cycle after request, dropped the next
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & !wb_ack_o;
      if (wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_we_i) begin
        unique case (wb_adr_i)
          5'(`OFF_CTRL): wb_dat_o <= ctrl;
          5'(`OFF_SRC): wb_dat_o <= 32'(src_addr);
          5'(`OFF_DST): wb_dat_o <= 32'(dst_addr);
          5'(`OFF_COUNT): wb_dat_o <= 32'(byte_count);
          `OFF_STATUS: wb_dat_o <= {28'h0, flag_conf, flag_abn, flag_done, !idle};
          `OFF_HOLD: wb_dat_o <= holding_register;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; start is a self-clearing request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= `CTRL_RESET;
      start_pending <= 1'b0;
    end else begin
      start_pending <= 1'b0;
      if (wb_wr && wb_adr_i == 5'(`OFF_CTRL) && idle) begin
        ctrl <= byte_merge(ctrl, wb_dat_i, wb_sel_i) & `CTRL_MASK;
        start_pending <= wb_sel_i[0] & wb_dat_i[`CTRL_START];
      end
    end
  end

  // Status flags: hardware set wins over write-one-to-clear
  wire logic status_wr = wb_wr && wb_adr_i == `OFF_STATUS && wb_sel_i[0];
  wire logic fail = idle & start_pending & cfg_error;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_done <= 1'b0;
      flag_abn <= 1'b0;
      flag_conf <= 1'b0;
    end else begin
      flag_abn <= fail | (flag_abn & !(status_wr & wb_dat_i[`STAT_ABN]));
      flag_conf <= fail | (flag_conf & !(status_wr & wb_dat_i[`STAT_CONF]));
      flag_done <= (state == ST_ACK && byte_count == '0) | (flag_done & !(status_wr & wb_dat_i[`STAT_DONE]));
    end
  end

  // Channel state, data movement and acknowledge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      src_addr <= '0;
      dst_addr <= '0;
      byte_count <= '0;
      holding_register <= 32'h0000_0000;
      piece_off <= 3'h0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_size <= 2'h0;
      mem_wdata <= 32'h0000_0000;
      transfer_acknowledge_n <= 1'b1;
    end else begin
      transfer_acknowledge_n <= 1'b1;
      unique case (state)
        ST_IDLE: begin
          if (wb_wr && wb_adr_i == 5'(`OFF_SRC)) src_addr <= ADDR_W'(byte_merge(32'(src_addr), wb_dat_i, wb_sel_i));
          if (wb_wr && wb_adr_i == 5'(`OFF_DST)) dst_addr <= ADDR_W'(byte_merge(32'(dst_addr), wb_dat_i, wb_sel_i));
          if (wb_wr && wb_adr_i == 5'(`OFF_COUNT)) byte_count <= CNT_W'(byte_merge(32'(byte_count), wb_dat_i, wb_sel_i));
          if (start_pending && !cfg_error) state <= ST_STANDBY;
        end
        ST_STANDBY: begin
          piece_off <= 3'h0;
          if (req_now) state <= ST_READ;
        end
        ST_READ, ST_WRITE: begin
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            piece_off <= last_piece ? 3'h0 : 3'(piece_off + step);
            if (state == ST_READ) begin
              holding_register <= (holding_register & ~(lane_mask(step) << {piece_off, 3'h0})) |
                                  ((mem_rdata & lane_mask(step)) << {piece_off, 3'h0});
              if (last_piece) state <= ST_WRITE;
            end else if (last_piece) begin
              src_addr <= src_addr + ADDR_W'(unit_bytes);
              dst_addr <= dst_addr + ADDR_W'(unit_bytes);
              byte_count <= count_after;
              if (!continuous || count_after == '0) begin
                state <= ST_ACK;
                transfer_acknowledge_n <= 1'b0;
              end else if (req_now) state <= ST_READ;
              else state <= ST_STANDBY;
            end
          end else if (!mem_req && !mem_ack) begin
            mem_req <= 1'b1;
            mem_we <= (state == ST_WRITE);
            mem_addr <= ((state == ST_WRITE) ? dst_addr : src_addr) + ADDR_W'(piece_off);
            mem_size <= (step == `BYTES_32) ? 2'h0 : (step == `BYTES_16) ? `SIZE_16 : `SIZE_8;
            mem_wdata <= (holding_register >> {piece_off, 3'h0}) & lane_mask(step);
          end
        end
        ST_ACK: begin
          if (byte_count == '0) state <= ST_IDLE;
          else if (use_pin && edge_pending) state <= ST_READ;
          else state <= ST_STANDBY;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_ack_pulse;
    !transfer_acknowledge_n |=> transfer_acknowledge_n && state != ST_WRITE;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge not a single low cycle");

  property p_ack_cause;
    $fell(transfer_acknowledge_n) |-> state == ST_ACK && $past(state) == ST_WRITE &&
      (!continuous || byte_count == '0);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without finished unit");

  property p_single_ack;
    state == ST_WRITE && mem_req && mem_ack && last_piece && !continuous |=> !transfer_acknowledge_n;
  endproperty
  a_single_ack: assert property (p_single_ack) else $error("single unit not acknowledged");

  property p_count_step;
    state == ST_WRITE && mem_req && mem_ack && last_piece |=>
      byte_count == $past(byte_count) - CNT_W'($past(unit_bytes)) &&
      src_addr == $past(src_addr) + ADDR_W'($past(unit_bytes));
  endproperty
  a_count_step: assert property (p_count_step) else $error("count or address step wrong");

  property p_conf_error;
    idle && start_pending && port_bytes > unit_bytes |=> flag_abn && flag_conf && state == ST_IDLE;
  endproperty
  a_conf_error: assert property (p_conf_error) else $error("prohibited size accepted");

  property p_polarity;
    idle && start_pending && ctrl[`CTRL_POL] |=> state == ST_IDLE ##1 state == ST_IDLE;
  endproperty
  a_polarity: assert property (p_polarity) else $error("started with polarity bit set");

  property p_read_first;
    $rose(state == ST_WRITE) |-> $past(state) == ST_READ && $past(mem_ack) && !mem_we;
  endproperty
  a_read_first: assert property (p_read_first) else $error("write phase without read");

  property p_standby_wait;
    state == ST_STANDBY && !req_now |=> state == ST_STANDBY;
  endproperty
  a_standby_wait: assert property (p_standby_wait) else $error("transfer without request");

  property p_edge_seen;
    use_pin && !level_mode && !idle && pin_prev && !pin_sync |=> edge_pending || state == ST_READ;
  endproperty
  a_edge_seen: assert property (p_edge_seen) else $error("falling edge lost");

  property p_piece_width;
    state == ST_READ && mem_req |-> mem_size == ((rd_step == `BYTES_32) ? 2'h0 : (rd_step == `BYTES_16) ?
      `SIZE_16 : `SIZE_8);
  endproperty
  a_piece_width: assert property (p_piece_width) else $error("read piece width wrong");

  property p_cov_single;
    !transfer_acknowledge_n ##1 state == ST_STANDBY;
  endproperty
  c_single: cover property (p_cov_single);

  property p_cov_done;
    $rose(flag_done);
  endproperty
  c_done: cover property (p_cov_done);

  property p_cov_split;
    state == ST_READ && mem_ack && !last_piece;
  endproperty
  c_split: cover property (p_cov_split);

endmodule
`default_nettype wire

// file: verification/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  // Clock, reset and pacing
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic slow,
  // Data bus slave
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:2047];
  logic [31:0] rd;
  int n_rd = 0;
  int n_wr = 0;
  int wait_cnt;
  int w;
  function automatic logic [7:0] rd_byte(input logic [31:0] a);
    return mem[a[10:0]];
  endfunction
  // Unwritten bytes hold a pattern of two address bytes
  initial begin
    for (int j = 0; j < 2048; j++) begin
      mem[j] = 8'(j) ^ 8'(j >> 8) ^ 8'h5a;
    end
  end
  // Piece width from size code, 0x is a full word
  assign w = mem_size[1] ? (mem_size[0] ? 1 : 2) : 4;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      wait_cnt <= 0;
      mem_rdata <= 32'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      // Released bus shows no stale data
      mem_rdata <= ~mem_rdata;
    end else if (mem_req) begin
      if (wait_cnt < (slow ? 3 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        mem_ack <= 1'b1;
        // Bytes beyond the piece are garbage
        for (int i = 0; i < 4; i++) begin
          if (mem_we && i < w) mem[11'(mem_addr + i)] = mem_wdata[8*i +: 8];
          rd[8*i +: 8] = (i < w) ? rd_byte(mem_addr + i) : ~rd_byte(mem_addr + i);
        end
        mem_rdata <= mem_we ? ~mem_rdata : rd;
        if (mem_we) n_wr++;
        else n_rd++;
      end
    end
  end
endmodule
`default_nettype wire

// file: verification/dma_ext_request_dual_xfer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dma_ext_request_dual_xfer_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, slow = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, v;
  logic interrupt_controller_n = 1'b1, pin_n = 1'b1, dack_n;
  logic mem_req, mem_we, mem_ack;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic [1:0] mem_size;
  logic [31:0] bad [3] = '{32'h0303, 32'h2203, 32'h0001};
  int n_fail = 0, n_tests = 0, n_ack = 0, cycles = 0, r0, w0, a0;

  dma_ext_request_dual_xfer u_dma_ext_request_dual_xfer (.core_clk(core_clk), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .interrupt_controller_transfer_request_n(interrupt_controller_n), .pin_transfer_request_n(pin_n),
    .transfer_acknowledge_n(dack_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  mem_model u_mem_model (.core_clk(core_clk), .rstn(rstn), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (dack_n === 1'b0) n_ack++;
    if (cycles == 30000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1) begin
      @(posedge core_clk);
    end
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic setup(input logic [31:0] c, s, d, n);
    bus(1'b1, 5'h10, 32'he);
    bus(1'b1, 5'h04, s);
    bus(1'b1, 5'h08, d);
    bus(1'b1, 5'h0c, n);
    bus(1'b1, 5'h00, c);
    repeat (2) @(posedge core_clk);
    r0 = u_mem_model.n_rd;
    w0 = u_mem_model.n_wr;
    a0 = n_ack;
  endtask
  task automatic wait_dack();
    @(posedge core_clk);
    while (dack_n !== 1'b0) begin
      @(posedge core_clk);
    end
  endtask
  task automatic edge_req();
    // Fresh falling edge for each unit
    pin_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    pin_n <= 1'b0;
    wait_dack();
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk("dack idle", {31'h0, dack_n}, 32'h1);
    bus(1'b0, 5'h18, 32'h0);
    chk("unmapped", v, 32'h0);
    // Word units over 16 and 8 bit memory buses
    for (int b = 0; b < 2; b++) begin
      slow <= b[0];
      setup(32'h20003 | (b << 16), 32'h100, 32'h200 + (b << 4), 32'h8);
      for (int q = 1; q < 3; q++) begin
        interrupt_controller_n <= 1'b0;
        wait_dack();
        interrupt_controller_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("reads", u_mem_model.n_rd - r0, (2 << b) * q);
        chk("writes", u_mem_model.n_wr - w0, (2 << b) * q);
        chk("acks", n_ack - a0, q);
        bus(1'b0, 5'h0c, 32'h0);
        chk("count", v, 32'h8 - 4 * q);
        bus(1'b0, 5'h04, 32'h0);
        chk("src", v, 32'h100 + 4 * q);
      end
      bus(1'b0, 5'h10, 32'h0);
      chk("status", v, 32'h2);
      for (int i = 0; i < 8; i++) begin
        chk("dst byte", {24'h0, u_mem_model.mem[11'(32'h200 + (b << 4) + i)]}, {24'h0, 8'(i) ^ 8'h5b});
      end
    end
    slow <= 1'b0;
    // Unit against I/O port size, codes 01..11
    for (int u = 1; u < 4; u++) begin
      for (int p = 1; p < 4; p++) begin
        setup(32'h43 | (u << 2) | (p << 4), 32'h40, 32'h80, 4 >> (u - 1));
        if (p < u) begin
          bus(1'b0, 5'h10, 32'h0);
          chk("prohibited", v, 32'hc);
        end else begin
          interrupt_controller_n <= 1'b0;
          wait_dack();
          interrupt_controller_n <= 1'b1;
          repeat (2) @(posedge core_clk);
          chk("io reads", u_mem_model.n_rd - r0, 1 << (p - u));
          chk("io writes", u_mem_model.n_wr - w0, 1);
        end
      end
    end
    foreach (bad[i]) begin
      setup(bad[i], 32'h100, 32'h200, 32'h8);
      bus(1'b0, 5'h10, 32'h0);
      chk("bad status", v, 32'hc);
      bus(1'b0, 5'h04, 32'h0);
      chk("src kept", v, 32'h100);
    end
    // Level pin, continuous, held low until acknowledge
    setup(32'h1303, 32'h100, 32'h300, 32'hc);
    pin_n <= 1'b0;
    wait_dack();
    pin_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("cont reads", u_mem_model.n_rd - r0, 3);
    chk("cont acks", n_ack - a0, 1);
    // Reset with the pin already low
    pin_n <= 1'b0;
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    setup(32'h203, 32'h100, 32'h400, 32'h8);
    repeat (20) @(posedge core_clk);
    chk("standby", u_mem_model.n_rd - r0, 0);
    edge_req();
    repeat (20) @(posedge core_clk);
    chk("one per edge", u_mem_model.n_rd - r0, 1);
    bus(1'b0, 5'h0c, 32'h0);
    chk("edge count", v, 32'h4);
    edge_req();
    repeat (4) @(posedge core_clk);
    bus(1'b0, 5'h10, 32'h0);
    chk("edge done", v, 32'h2);
    close_out();
  end
endmodule
`default_nettype wire
